/* File: tgc_pkg.sv */
/*
 * Constants shared by the timer gate control block: register offsets,
 * field positions, reset values and gate source codes.
 * Assumes a 32-bit register port with byte offsets on word boundaries.
 */
package tgc_pkg;
    // ========================================================
    // Register map
    // ========================================================
    localparam int          ADDR_W   = 8;
    localparam logic [7:0]  OFS_CTRL = 8'h00;   // Counter control
    localparam logic [7:0]  OFS_GATE = 8'h04;   // Gate control
    localparam logic [7:0]  OFS_FLAG = 8'h08;   // Flags, write one to clear
    localparam logic [7:0]  OFS_IEN  = 8'h0C;   // Interrupt enables
    localparam logic [7:0]  OFS_CNT  = 8'h10;   // 16-bit count
    // Control fields
    localparam int B_ON = 0, B_ASYNC = 1, B_CCS = 2, B_OSC = 4;
    // Gate fields
    localparam int B_GCE = 0, B_POL = 1, B_TGL = 2, B_SPM = 3;
    localparam int B_ARM = 4, B_LVL = 5, B_GSS = 6;
    // Flag and enable fields
    localparam int B_OVF = 0, B_GEV = 1, B_PIE = 2, B_GIE = 3;
    // ========================================================
    // Values
    // ========================================================
    localparam logic [1:0]  GSS_PIN  = 2'h0;    // Gate input pin
    localparam logic [1:0]  GSS_T8   = 2'h1;    // Eight-bit timer wrap
    localparam logic [1:0]  GSS_C1   = 2'h2;    // Comparator 1
    localparam logic [1:0]  GSS_C2   = 2'h3;    // Comparator 2
    localparam logic [1:0]  CCS_EXT  = 2'h2;    // External count clock
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam logic [15:0] CNT_RST  = 16'h0000;
endpackage

/* File: tgc_gate_if.sv */
/*
 * Carrier between the top and the gate path.
 * Assumes both ends run on core_clk.
 */
interface tgc_gate_if;
    logic src;      // Selected, sampled gate source
    logic pol;      // Gate polarity
    logic tgl;      // Toggle mode
    logic spm;      // Single-pulse mode
    logic on;       // Counter on
    logic arm_set;  // Software writes arm to one
    logic arm_clr;  // Software writes arm to zero
    logic arm;      // Arm state
    logic level;    // Gate control level
    logic fall;     // One-cycle falling edge of level
    modport ctl  (output src, pol, tgl, spm, on, arm_set, arm_clr, input arm, level, fall);
    modport gate (input src, pol, tgl, spm, on, arm_set, arm_clr, output arm, level, fall);
endinterface

/* File: tgc_sync.sv */
/*
 * Two flip-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a level that needs no word coherence.
 */
module tgc_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;   // First stage, read only by second
        logic [W-1:0] s2;   // Second stage
    } tgc_sync_s;
    tgc_sync_s s_q, s_d;
    // Next state
    always_comb begin
        s_d    = s_q;
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end
    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign q = s_q.s2;
endmodule

/* File: tgc_gate.sv */
/*
 * Gate path: polarity, toggle flip-flop, single-pulse arming, gate level
 * and its falling-edge event. Assumes a source already sampled to core_clk.
 */
module tgc_gate
    import tgc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    tgc_gate_if.gate  g
);
    typedef struct packed {
        logic act;      // Active-high source, previous cycle
        logic tff;      // Toggle flip-flop
        logic tout;     // Toggle stage output, previous cycle
        logic spa;      // Single pulse under way
        logic arm;      // Arm bit
        logic lvl;      // Gate level
        logic fall;     // Falling edge of level
    } tgc_gate_s;
    tgc_gate_s s_q, s_d;
    logic act, rise_act, tout, rise_t, lvl;
    // Next state of the gate path
    always_comb begin
        s_d      = s_q;
        act      = g.src ^ ~g.pol;
        rise_act = act & ~s_q.act;
        s_d.act  = act;
        if (!g.on || !g.tgl) begin
            s_d.tff = 1'b0;
        end else if (rise_act) begin
            s_d.tff = ~s_q.tff;
        end
        tout     = g.tgl ? s_q.tff : s_q.act;
        rise_t   = tout & ~s_q.tout;
        s_d.tout = tout;
        if (!g.spm) begin
            s_d.spa = 1'b0;
        end else if (rise_t && s_q.arm) begin
            s_d.spa = 1'b1;
        end
        lvl      = g.spm ? (tout & s_d.spa) : tout;
        s_d.lvl  = lvl;
        s_d.fall = s_q.lvl & ~lvl;
        // Software set wins over the hardware clear
        if (g.arm_set) begin
            s_d.arm = 1'b1;
        end else if (g.arm_clr) begin
            s_d.arm = 1'b0;
        end else if (g.spm && s_q.lvl && !lvl) begin
            s_d.arm = 1'b0;
            s_d.spa = 1'b0;
        end
    end
    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign g.arm   = s_q.arm;
    assign g.level = s_q.lvl;
    assign g.fall  = s_q.fall;
    // Checks
    AST_TFF_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n) !g.tgl |=> !s_q.tff) else $error("toggle ff not held clear");
    AST_TFF_FLIP: assert property (@(posedge core_clk) disable iff (!rst_n) g.tgl && g.on && rise_act |=> s_q.tff != $past(s_q.tff)) else $error("toggle ff missed edge");
    AST_ARM_DONE: assert property (@(posedge core_clk) disable iff (!rst_n) g.spm && s_q.lvl && !lvl && !g.arm_set |=> !s_q.arm) else $error("arm not cleared at trailing edge");
    AST_SPM_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n) g.spm && !s_q.arm && !s_q.spa && !g.arm_set ##1 g.spm |=> !s_q.lvl) else $error("gate open while disarmed");
endmodule

/* File: tgc_top.sv */
/*
 * Timer gate control top: register port, gate source selection,
 * 16-bit gated counter, flags, interrupt and wake requests.
 * Assumes counter_clock runs below a quarter of core_clk, the timer wrap
 * pulse and the sync selects come from core_clk logic, and the pins are
 * asynchronous.
 */
// Strobed register access and the address map were chosen for this implementation.
module tgc_top
    import tgc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    // Gate sources and count clock
    input  wire logic              gate_input_pin,
    input  wire logic              counter_clock,
    input  wire logic              tmr8_wrap,
    input  wire logic              cmp1_out,
    input  wire logic              cmp2_out,
    input  wire logic              cmp1_sync_sel,
    input  wire logic              cmp2_sync_sel,
    // System state and requests
    input  wire logic              sleep_mode,
    output logic                   irq,
    output logic                   wake,
    output logic                   osc_run
);
    // ========================================================
    // State
    // ========================================================
    typedef struct packed {
        logic        on;        // Counter on
        logic        async_sel; // Asynchronous counting
        logic [1:0]  ccs;       // Count clock select
        logic        osc_en;    // Crystal oscillator enable
        logic        gce;       // Gate count enable
        logic        pol;       // Gate polarity
        logic        tgl;       // Toggle mode
        logic        spm;       // Single-pulse mode
        logic [1:0]  gss;       // Gate source select
        logic        ovf_f;     // Overflow flag
        logic        gev_f;     // Gate event flag
        logic        ovf_ie;    // Overflow interrupt enable
        logic        gev_ie;    // Gate event interrupt enable
        logic        pie;       // Peripheral interrupt enable
        logic        global_irq_enable;       // Global interrupt enable
        logic [15:0] cnt;       // Count
        logic        cclk;      // Count clock, previous cycle
        logic        c1s;       // Comparator 1 sampled on count clock
        logic        c2s;       // Comparator 2 sampled on count clock
        logic        t8p;       // Timer wrap pulse
        logic [31:0] rdata;     // Read data
        logic        irq;       // Interrupt request
        logic        wake;      // Wake request
        logic        osc;       // Oscillator run
    } tgc_top_s;

    tgc_top_s    s_q, s_d;      // Registered and next state
    logic        rst_sync_n;    // Released reset
    logic [3:0]  sy;            // Sampled pins: clock, c2, c1, gate pin
    logic        cclk_rise;     // Count clock rising edge
    logic        count_ok;      // Counting allowed this cycle
    logic        inc;           // Increment now
    logic        cnt_wr;        // Software count write
    logic        ovf;           // Wrap of the count
    logic        comparator1_sync_out;  // Comparator 1 as chosen
    logic        comparator2_sync_out;  // Comparator 2 as chosen
    logic        sel_src;       // Selected gate source
    logic        sleep_ok;      // Sleep does not block counting
    logic [31:0] flag_clr;      // Write-one-to-clear mask

    tgc_gate_if g ();

    // ========================================================
    // Reset release and pin sampling
    // ========================================================
    // Reset enters asynchronously, released after two edges
    tgc_sync #(.W(1)) u_rst (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        (1'b1),
        .q        (rst_sync_n)
    );

    // Pins pass two flip-flops before use
    tgc_sync #(.W(4)) u_pins (
        .core_clk (core_clk),
        .rst_n    (rst_sync_n),
        .d        ({counter_clock, cmp2_out, cmp1_out, gate_input_pin}),
        .q        (sy)
    );

    // ========================================================
    // Gate path
    // ========================================================
    tgc_gate u_gate (
        .core_clk (core_clk),
        .rst_n    (rst_sync_n),
        .g        (g)
    );

    // Source selection and controls handed to the gate path
    always_comb begin
        comparator1_sync_out = cmp1_sync_sel ? s_q.c1s : sy[1];
        comparator2_sync_out = cmp2_sync_sel ? s_q.c2s : sy[2];
        if (s_q.gss == GSS_PIN) begin
            sel_src = sy[0];
        end else if (s_q.gss == GSS_T8) begin
            sel_src = s_q.t8p;
        end else if (s_q.gss == GSS_C1) begin
            sel_src = comparator1_sync_out;
        end else begin
            sel_src = comparator2_sync_out;
        end
    end

    assign g.src     = sel_src;
    assign g.pol     = s_q.pol;
    assign g.tgl     = s_q.tgl;
    assign g.spm     = s_q.spm;
    assign g.on      = s_q.on;
    assign g.arm_set = reg_wr && (reg_addr == OFS_GATE) && reg_wdata[B_ARM];
    assign g.arm_clr = reg_wr && (reg_addr == OFS_GATE) && !reg_wdata[B_ARM];

    // ========================================================
    // Counter control terms
    // ========================================================
    always_comb begin
        cclk_rise = sy[3] & ~s_q.cclk;
        sleep_ok  = !sleep_mode || (s_q.async_sel && s_q.ccs == CCS_EXT);
        count_ok  = s_q.on && (!s_q.gce || g.level) && sleep_ok;
        inc       = cclk_rise && count_ok;
        cnt_wr    = reg_wr && (reg_addr == OFS_CNT);
        ovf       = inc && !cnt_wr && (s_q.cnt == CNT_MAX);
        flag_clr  = (reg_wr && reg_addr == OFS_FLAG) ? reg_wdata : 32'h0000_0000;
    end

    // ========================================================
    // Next state
    // ========================================================
    always_comb begin
        s_d       = s_q;
        s_d.cclk  = sy[3];
        s_d.t8p   = tmr8_wrap;
        // Comparators sampled at the count clock when asked
        if (cclk_rise) begin
            s_d.c1s = sy[1];
            s_d.c2s = sy[2];
        end
        // Register writes, address decode
        if (reg_wr) begin
            if (reg_addr == OFS_CTRL) begin
                s_d.on        = reg_wdata[B_ON];
                s_d.async_sel = reg_wdata[B_ASYNC];
                s_d.ccs       = reg_wdata[B_CCS +: 2];
                s_d.osc_en    = reg_wdata[B_OSC];
            end else if (reg_addr == OFS_GATE) begin
                s_d.gce = reg_wdata[B_GCE];
                s_d.pol = reg_wdata[B_POL];
                s_d.tgl = reg_wdata[B_TGL];
                s_d.spm = reg_wdata[B_SPM];
                s_d.gss = reg_wdata[B_GSS +: 2];
            end else if (reg_addr == OFS_IEN) begin
                s_d.ovf_ie = reg_wdata[B_OVF];
                s_d.gev_ie = reg_wdata[B_GEV];
                s_d.pie    = reg_wdata[B_PIE];
                s_d.global_irq_enable    = reg_wdata[B_GIE];
            end
        end
        // Count: a software write wins over an increment
        if (cnt_wr) begin
            s_d.cnt = reg_wdata[15:0];
        end else if (inc) begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
        // Flags: a set in the clearing cycle wins
        s_d.ovf_f = (s_q.ovf_f & ~flag_clr[B_OVF]) | ovf;
        s_d.gev_f = (s_q.gev_f & ~flag_clr[B_GEV]) | g.fall;
        // Requests
        s_d.irq  = (s_q.ovf_f && s_q.ovf_ie && s_q.on && s_q.pie && s_q.global_irq_enable)
                 || (s_q.gev_f && s_q.gev_ie && s_q.pie && s_q.global_irq_enable);
        s_d.wake = sleep_mode && s_q.ovf_f && s_q.ovf_ie && s_q.pie && s_q.on;
        s_d.osc  = s_q.osc_en;
        // Read data, answered in the next cycle
        s_d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == OFS_CTRL) begin
                s_d.rdata[B_ON]       = s_q.on;
                s_d.rdata[B_ASYNC]    = s_q.async_sel;
                s_d.rdata[B_CCS +: 2] = s_q.ccs;
                s_d.rdata[B_OSC]      = s_q.osc_en;
            end else if (reg_addr == OFS_GATE) begin
                s_d.rdata[B_GCE]      = s_q.gce;
                s_d.rdata[B_POL]      = s_q.pol;
                s_d.rdata[B_TGL]      = s_q.tgl;
                s_d.rdata[B_SPM]      = s_q.spm;
                s_d.rdata[B_ARM]      = g.arm;
                s_d.rdata[B_LVL]      = g.level;
                s_d.rdata[B_GSS +: 2] = s_q.gss;
            end else if (reg_addr == OFS_FLAG) begin
                s_d.rdata[B_OVF] = s_q.ovf_f;
                s_d.rdata[B_GEV] = s_q.gev_f;
            end else if (reg_addr == OFS_IEN) begin
                s_d.rdata[B_OVF] = s_q.ovf_ie;
                s_d.rdata[B_GEV] = s_q.gev_ie;
                s_d.rdata[B_PIE] = s_q.pie;
                s_d.rdata[B_GIE] = s_q.global_irq_enable;
            end else if (reg_addr == OFS_CNT) begin
                s_d.rdata[15:0] = s_q.cnt;
            end
        end
    end

    // ========================================================
    // State register
    // ========================================================
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_q     <= '0;
            s_q.cnt <= CNT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = s_q.rdata;
    assign irq       = s_q.irq;
    assign wake      = s_q.wake;
    assign osc_run   = s_q.osc;

    // ========================================================
    // Checks
    // ========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    sequence seq_wrap;
        inc && !cnt_wr && (s_q.cnt == CNT_MAX);
    endsequence
    sequence seq_held;
        !inc && !cnt_wr;
    endsequence

    AST_OVF_SET: assert property (seq_wrap |=> s_q.ovf_f && s_q.cnt == CNT_RST)
        else $error("wrap did not set overflow flag");
    AST_INCR: assert property (inc && !cnt_wr |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
        else $error("count did not increment");
    AST_OFF_HOLD: assert property (!s_q.on && !cnt_wr |=> $stable(s_q.cnt))
        else $error("count moved while off");
    AST_GATE_HOLD: assert property (s_q.gce && !g.level && !cnt_wr |=> $stable(s_q.cnt))
        else $error("count moved while gate closed");
    AST_SLEEP_HOLD: assert property (sleep_mode && !s_q.async_sel && !cnt_wr |=> $stable(s_q.cnt))
        else $error("count moved in sleep without asynchronous mode");
    AST_IRQ_GATED: assert property (s_q.irq |-> $past(s_q.global_irq_enable) && $past(s_q.pie))
        else $error("interrupt without global enables");
    AST_IRQ_OVF: assert property (s_q.ovf_f && s_q.ovf_ie && s_q.on && s_q.pie && s_q.global_irq_enable ##1 s_q.ovf_f |-> s_q.irq)
        else $error("overflow interrupt missing");
    AST_WAKE: assert property (sleep_mode && s_q.ovf_f && s_q.ovf_ie && s_q.pie && s_q.on |=> s_q.wake)
        else $error("no wake on overflow in sleep");
    AST_OSC_SLEEP: assert property (sleep_mode && s_q.osc_en ##1 seq_held |-> osc_run)
        else $error("oscillator stopped in sleep");
    AST_GEV: assert property (g.fall |=> s_q.gev_f ##1 (s_q.gev_f || $past(flag_clr[B_GEV])))
        else $error("gate event flag not set");
    AST_LEVEL_READ: assert property (reg_rd && reg_addr == OFS_GATE |=> reg_rdata[B_LVL] == $past(g.level))
        else $error("gate level read wrong");
endmodule

/* File: tgc_far_model.sv */
/*
 * Far-side model: gate pin, comparator outputs and count clock.
 * Assumes it is driven by calls from the bench on core_clk.
 */
module tgc_far_model (
    input  wire logic core_clk,
    output logic      counter_clock,
    output logic      gate_input_pin,
    output logic      cmp1_out,
    output logic      cmp2_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Idle levels
    // ==========================================
    initial begin
        counter_clock  = 1'b0;
        gate_input_pin = 1'b0;
        cmp1_out       = 1'b0;
        cmp2_out       = 1'b0;
    end
    // Chosen source gets v, the others the inverse, then settle
    task automatic set_src(input logic [1:0] s, input logic v);
        @(posedge core_clk);
        gate_input_pin <= (s == 2'h0) ? v : ~v;
        cmp1_out       <= (s == 2'h2) ? v : ~v;
        cmp2_out       <= (s == 2'h3) ? v : ~v;
        repeat (8) @(posedge core_clk);
    endtask
    // Count clock runs only for n rising edges, 4 cycles per level
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge core_clk);
            counter_clock <= 1'b1;
            repeat (4) @(posedge core_clk);
            counter_clock <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
    endtask
endmodule

/* File: tb_top.sv */
/*
 * Self-checking bench for the timer gate control block.
 * Assumes the register map and field positions of tgc_pkg.
 */
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tgc_pkg::*;
    // ==========================================
    // Signals
    // ==========================================
    logic              core_clk = 1'b0, rst_n = 1'b0, sleep_mode = 1'b0;
    logic              reg_wr   = 1'b0, reg_rd = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0]       reg_wdata = '0, reg_rdata, rv;
    logic              counter_clock, gate_input_pin, cmp1_out, cmp2_out;
    logic              irq, wake, osc_run;
    logic              tmr8_wrap = 1'b0, cmp_sync_sel = 1'b0;
    int                n_mismatch = 0, checked = 0;
    always #5 core_clk = ~core_clk;
    tgc_far_model far (.core_clk(core_clk), .counter_clock(counter_clock),
        .gate_input_pin(gate_input_pin), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out));
    tgc_top DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .gate_input_pin(gate_input_pin), .counter_clock(counter_clock), .tmr8_wrap(tmr8_wrap),
        .cmp1_out(cmp1_out), .cmp2_out(cmp2_out), .cmp1_sync_sel(cmp_sync_sel),
        .cmp2_sync_sel(cmp_sync_sel), .sleep_mode(sleep_mode), .irq(irq), .wake(wake),
        .osc_run(osc_run));
    // ==========================================
    // Register port tasks
    // ==========================================
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Send n count clock edges, then compare the count
    task automatic run(input int n, input logic [31:0] e);
        far.pulse(n);
        repeat (6) @(posedge core_clk);
        rd(OFS_CNT, rv);
        `CHK(rv, e)
    endtask
    // One source, polarity and level combination with the gate enabled
    task automatic gate_case(input logic [1:0] s, input logic pol, input logic lvl);
        far.set_src(s, lvl);
        wr(OFS_CNT, 32'h0);
        wr(OFS_GATE, {24'h0, s, 4'h0, pol, 1'b1});
        run(2, (lvl == pol) ? 32'h2 : 32'h0);
        rd(OFS_GATE, rv);
        `CHK(rv[B_LVL], lvl == pol)
    endtask
    // One timer wrap pulse, then let the toggle stage settle
    task automatic t8();
        @(posedge core_clk);
        tmr8_wrap <= 1'b1;
        @(posedge core_clk);
        tmr8_wrap <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    // Read the gate level and compare
    task automatic lvl_is(input logic e);
        rd(OFS_GATE, rv);
        `CHK(rv[B_LVL], e)
    endtask
    task automatic results;
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==========================================
    // Watchdog
    // ==========================================
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        results();
    end
    // ==========================================
    // Test sequence
    // ==========================================
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(OFS_CTRL, rv);
        `CHK(rv, 32'h0)
        rd(8'h20, rv); // Unmapped place reads zero
        `CHK(rv, 32'h0)
        run(3, 32'h0);
        wr(OFS_CTRL, 32'h1);
        run(3, 32'h3);
        // Every source but the timer wrap, both polarities, both levels
        for (int s = 0; s < 4; s++) begin
            if (s != 1) for (int k = 0; k < 4; k++) gate_case(s[1:0], k[1], k[0]);
        end
        // Gate event with gate enable clear
        wr(OFS_GATE, 32'h2);
        far.set_src(2'h0, 1'b1);
        wr(OFS_FLAG, 32'h3);
        far.set_src(2'h0, 1'b0);
        rd(OFS_FLAG, rv);
        `CHK(rv[B_GEV], 1'b1)
        wr(OFS_IEN, 32'hE);
        repeat (3) @(posedge core_clk);
        `CHK(irq, 1'b1)
        wr(OFS_FLAG, 32'h2);
        wr(OFS_IEN, 32'h0);
        // Overflow and its interrupt enables
        wr(OFS_GATE, 32'h0);
        wr(OFS_CNT, 32'hFFFF);
        run(1, 32'h0);
        rd(OFS_FLAG, rv);
        `CHK(rv[B_OVF], 1'b1)
        wr(OFS_IEN, 32'hD);
        repeat (3) @(posedge core_clk);
        `CHK(irq, 1'b1)
        wr(OFS_IEN, 32'h5);
        repeat (3) @(posedge core_clk);
        `CHK(irq, 1'b0)
        wr(OFS_FLAG, 32'h1);
        // Sleep: synchronous mode holds, asynchronous external mode wakes
        sleep_mode <= 1'b1;
        wr(OFS_CNT, 32'hFFFF);
        run(1, 32'hFFFF);
        wr(OFS_CTRL, 32'h1B);
        run(1, 32'h0);
        `CHK(wake, 1'b1)
        `CHK(irq, 1'b0)
        `CHK(osc_run, 1'b1)
        sleep_mode <= 1'b0;
        wr(OFS_FLAG, 32'h3);
        wr(OFS_CTRL, 32'h1);
        // Single pulse: mode first, then arm; one pulse counted only
        far.set_src(2'h0, 1'b0);
        wr(OFS_CNT, 32'h0);
        wr(OFS_GATE, 32'h0B);
        wr(OFS_GATE, 32'h1B);
        far.set_src(2'h0, 1'b1);
        run(2, 32'h2);
        far.set_src(2'h0, 1'b0);
        rd(OFS_GATE, rv);
        `CHK(rv[B_ARM], 1'b0)
        far.set_src(2'h0, 1'b1);
        run(2, 32'h2);
        wr(OFS_GATE, 32'h03);
        // Synchronised comparator follows only at count clock edges
        cmp_sync_sel <= 1'b1;
        wr(OFS_GATE, 32'h82);
        far.set_src(2'h2, 1'b0);
        far.pulse(1);
        far.set_src(2'h2, 1'b1);
        lvl_is(1'b0);
        far.pulse(1);
        lvl_is(1'b1);
        cmp_sync_sel <= 1'b0;
        // Eight-bit timer wraps through the toggle flip-flop
        wr(OFS_GATE, 32'h42);
        wr(OFS_GATE, 32'h46);
        t8();
        lvl_is(1'b1);
        t8();
        lvl_is(1'b0);
        t8();
        wr(OFS_GATE, 32'h42);
        wr(OFS_GATE, 32'h46);
        lvl_is(1'b0);
        // Toggle and single pulse: one full source cycle counted
        far.set_src(2'h0, 1'b0);
        wr(OFS_CNT, 32'h0);
        wr(OFS_GATE, 32'h0F);
        wr(OFS_GATE, 32'h1F);
        far.set_src(2'h0, 1'b1);
        run(1, 32'h1);
        far.set_src(2'h0, 1'b0);
        run(1, 32'h2);
        far.set_src(2'h0, 1'b1);
        run(1, 32'h2);
        rd(OFS_GATE, rv);
        `CHK(rv[B_ARM], 1'b0)
        wr(OFS_GATE, 32'h07);
        results();
    end
endmodule
